// *** hdl/gcls_pkg.sv ***
// constants and types of the gateway control lead sequencer
package gcls_pkg;

    // clock and timing base
    localparam int CLK_PERIOD_NS   = 10;
    localparam int TICK_PERIOD_NS  = 1000000;
    localparam int TICK_PERIOD_MS  = 1;
    localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // longest wait for carrier on an outbound call, rounded down to ticks
    localparam int CARRIER_TIMEOUT_MS    = 35000;
    localparam int CARRIER_TIMEOUT_TICKS = CARRIER_TIMEOUT_MS / TICK_PERIOD_MS;

    // least time of the disconnect pulse, rounded up to ticks
    localparam int DTR_DROP_MS    = 200;
    localparam int DTR_DROP_TICKS = (DTR_DROP_MS + TICK_PERIOD_MS - 1) / TICK_PERIOD_MS;

    // hotline retry spacing, software can change it
    localparam int HOTLINE_GAP_MS_RESET = 10000;

    localparam int TIMER_W  = 16;
    localparam int MODE_W   = 4;
    localparam int RATE_W   = 4;
    localparam int PADDR_W  = 12;

    // register byte addresses
    localparam logic [PADDR_W-1:0] ADDR_CTRL   = 12'h000;
    localparam logic [PADDR_W-1:0] ADDR_GAP    = 12'h004;
    localparam logic [PADDR_W-1:0] ADDR_STATUS = 12'h008;

    // control register fields
    localparam int CTRL_MODE_LSB     = 0;
    localparam int CTRL_RATE_DET_BIT = 4;
    localparam int CTRL_RATE_LSB     = 8;

    // status register fields
    localparam int STAT_STATE_LSB  = 0;
    localparam int STAT_DTR_BIT    = 4;
    localparam int STAT_BUSY_BIT   = 5;
    localparam int STAT_PROMPT_BIT = 6;
    localparam int STAT_DCD_BIT    = 7;
    localparam int STAT_DSR_BIT    = 8;

    // operating modes
    localparam logic [MODE_W-1:0] MODE_STRAP      = 4'h3;
    localparam logic [MODE_W-1:0] MODE_GW_PLAIN   = 4'h4;
    localparam logic [MODE_W-1:0] MODE_GW_HOT     = 4'h5;
    localparam logic [MODE_W-1:0] MODE_GW_PLAIN_D = 4'h6;
    localparam logic [MODE_W-1:0] MODE_GW_HOT_D   = 4'h7;

    // reset values
    localparam logic [MODE_W-1:0] CTRL_MODE_RESET     = MODE_GW_PLAIN;
    localparam logic              CTRL_RATE_DET_RESET = 1'b1;
    localparam logic [RATE_W-1:0] CTRL_RATE_RESET     = 4'h0;

    // interface role: low means terminal equipment side
    localparam logic ROLE_DTE = 1'b0;

    typedef struct packed {
        logic [RATE_W-1:0] rate;
        logic              rate_detect_enable;
        logic [MODE_W-1:0] mode;
    } gcls_cfg_type;

    typedef struct packed {
        logic dcd;
        logic dsr;
    } gcls_leads_type;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_INBOUND,
        ST_OUT_WAIT,
        ST_OUT_LINK,
        ST_HOT_CALL,
        ST_HOT_LINK,
        ST_DISC
    } gcls_state_type;

endpackage

// *** hdl/gcls_tick.sv ***
// divider that makes the one-cycle timing tick
`timescale 1ns/1ps
`default_nettype none
module gcls_tick
    import gcls_pkg::*;
#(
    parameter int CYCLES = TICK_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    logic [31:0] count;
    wire logic   at_end;

    assign at_end = (count == 32'(CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 32'h0;
            tick  <= 1'b0;
        end else begin
            count <= at_end ? 32'h0 : count + 32'h1;
            tick  <= at_end;
        end
    end
endmodule
`default_nettype wire

// *** hdl/gcls_timer.sv ***
// tick counter with synchronous clear and a limit compare
`timescale 1ns/1ps
`default_nettype none
module gcls_timer
    import gcls_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               clear,
    input  wire logic               tick,
    input  wire logic [TIMER_W-1:0] limit,
    output logic                    expired
);
    logic [TIMER_W-1:0] count;

    assign expired = (count >= limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (tick && !expired) begin
            count <= count + 16'h1;
        end
    end
endmodule
`default_nettype wire

// *** hdl/gcls_top.sv ***
// control lead sequencer facing a gateway, with its apb registers
// Contract
// - act as DTE, drive DTR, watch DSR/DCD
// - ring indicate lead is ignored
// - prompts only inbound, never while DCD off
// - modes 4/5: DTR on only during calls
// - modes 6/7: DTR on, 0.2 s drop
// - outbound: answer, raise DTR, transparent link; modes 5/7 refuse outbound offers instead
// - modes 4/5: 35 s carrier wait, release
// - DSR or DCD falling releases call
// - DCD rise: DTR on, busy, rate detect
// - mode 5: hotline on DCD, retry
// - hotline rate from configured rate settings
// - mode 6 is mode 4 with DTR on; the code has no 35 s carrier timeout in mode 6
// - mode 7 is mode 5 with DTR on
// - mode 3: DTE, no prompts, DTR, hotline
// - inbound call refuses outbound calls
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module gcls_top
    import gcls_pkg::*;
#(
    parameter int TICK_LEN        = TICK_CYCLES,
    parameter int CARRIER_TICKS   = CARRIER_TIMEOUT_TICKS,
    parameter int HOTLINE_GAP_RST = HOTLINE_GAP_MS_RESET
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               dsr_in,
    input  wire logic               dcd_in,
    output logic                    dtr_out,
    input  wire logic               call_offer,
    input  wire logic               peer_release,
    input  wire logic               hotline_answered,
    output logic                    call_answer,
    output logic                    call_refuse,
    output logic                    call_release,
    output logic                    hotline_place,
    output logic                    busy_outbound,
    output logic                    transparent_link,
    output logic                    rate_detect_ready,
    output logic                    prompt_enable,
    output logic                    rate_detect_enable,
    output logic [RATE_W-1:0]       hotline_rate,
    output logic                    interface_role_select,
    output logic                    hotline_select
);

    function automatic logic is_gateway(input logic [MODE_W-1:0] m);
        return (m == MODE_GW_PLAIN) || (m == MODE_GW_HOT) || (m == MODE_GW_PLAIN_D) || (m == MODE_GW_HOT_D);
    endfunction

    function automatic logic is_hot(input logic [MODE_W-1:0] m);
        return (m == MODE_GW_HOT) || (m == MODE_GW_HOT_D);
    endfunction

    function automatic logic is_pulse(input logic [MODE_W-1:0] m);
        return (m == MODE_GW_PLAIN_D) || (m == MODE_GW_HOT_D);
    endfunction

    gcls_cfg_type       cfg;
    logic [TIMER_W-1:0] hotline_gap;
    gcls_state_type     state;
    gcls_state_type     next_state;
    gcls_leads_type     leads_q;
    logic               next_answer;
    logic               next_release;
    logic               next_place;
    logic               retry;

    wire logic               gw_mode;
    wire logic               hot_mode;
    wire logic               pulse_mode;
    wire logic               strap_mode;
    wire logic               dcd_rise;
    wire logic               lead_drop;
    wire logic               established;
    wire logic               tick;
    wire logic               timer_clear;
    wire logic               timer_expired;
    wire logic [TIMER_W-1:0] timer_limit;
    wire logic               next_dtr;
    wire logic               next_prompt;
    wire logic               next_refuse;
    wire logic               setup_phase;
    wire logic               access_phase;
    wire logic               addr_hit;
    wire logic [31:0]        status_word;
    wire logic [31:0]        read_word;

    assign gw_mode    = is_gateway(cfg.mode);
    assign hot_mode   = is_hot(cfg.mode);
    assign pulse_mode = is_pulse(cfg.mode);
    assign strap_mode = (cfg.mode == MODE_STRAP);

    assign dcd_rise    = dcd_in && !leads_q.dcd;
    assign lead_drop   = (leads_q.dcd && !dcd_in) || (leads_q.dsr && !dsr_in);
    assign established = (state == ST_INBOUND) || (state == ST_OUT_LINK) || (state == ST_HOT_LINK);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            leads_q <= '0;
        end else begin
            leads_q <= '{dcd: dcd_in, dsr: dsr_in};
        end
    end

    gcls_tick #(
        .CYCLES (TICK_LEN)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    gcls_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (timer_clear),
        .tick    (tick),
        .limit   (timer_limit),
        .expired (timer_expired)
    );

    assign timer_limit = (state == ST_OUT_WAIT) ? TIMER_W'(CARRIER_TICKS) :
                         (state == ST_DISC)     ? TIMER_W'(DTR_DROP_TICKS) : hotline_gap;
    assign timer_clear = (next_state != state) || retry;

    always_comb begin
        next_state   = state;
        next_answer  = 1'b0;
        next_release = 1'b0;
        next_place   = 1'b0;
        retry        = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (dcd_rise && hot_mode) begin
                    next_state = ST_HOT_CALL;
                    next_place = 1'b1;
                end else if (dcd_rise) begin
                    next_state = ST_INBOUND;
                end else if (call_offer && !hot_mode) begin
                    next_state  = ST_OUT_WAIT;
                    next_answer = 1'b1;
                end
            end
            ST_INBOUND, ST_OUT_LINK, ST_HOT_LINK: begin
                if (lead_drop || peer_release) begin
                    next_state   = pulse_mode ? ST_DISC : ST_IDLE;
                    next_release = 1'b1;
                end
            end
            ST_OUT_WAIT: begin
                if (peer_release) begin
                    next_state   = ST_IDLE;
                    next_release = 1'b1;
                end else if (dcd_in) begin
                    next_state = ST_OUT_LINK;
                end else if (timer_expired && !pulse_mode) begin
                    next_state   = ST_IDLE;
                    next_release = 1'b1;
                end
            end
            ST_HOT_CALL: begin
                if (!dcd_in) begin
                    next_state   = ST_IDLE;
                    next_release = 1'b1;
                end else if (hotline_answered) begin
                    next_state = ST_HOT_LINK;
                end else if (timer_expired) begin
                    retry      = 1'b1;
                    next_place = 1'b1;
                end
            end
            ST_DISC: begin
                if (timer_expired) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (!gw_mode) begin
            next_state   = ST_IDLE;
            next_answer  = 1'b0;
            next_release = 1'b0;
            next_place   = 1'b0;
            retry        = 1'b0;
        end
    end

    assign next_refuse = call_offer && !(gw_mode && !hot_mode && (state == ST_IDLE) && !dcd_rise);

    assign next_dtr = strap_mode ? 1'b1 :
                      !gw_mode   ? 1'b0 :
                      pulse_mode ? (next_state != ST_DISC) : (next_state != ST_IDLE);

    assign next_prompt = dcd_in && !strap_mode &&
                         ((next_state == ST_INBOUND) || (next_state == ST_HOT_CALL) || (next_state == ST_HOT_LINK));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state             <= ST_IDLE;
            dtr_out           <= 1'b0;
            call_answer       <= 1'b0;
            call_refuse       <= 1'b0;
            call_release      <= 1'b0;
            hotline_place     <= 1'b0;
            busy_outbound     <= 1'b0;
            transparent_link  <= 1'b0;
            rate_detect_ready <= 1'b0;
            prompt_enable     <= 1'b0;
        end else begin
            state             <= next_state;
            dtr_out           <= next_dtr;
            call_answer       <= next_answer;
            call_refuse       <= next_refuse;
            call_release      <= next_release;
            hotline_place     <= next_place;
            busy_outbound     <= (next_state != ST_IDLE);
            transparent_link  <= (next_state == ST_OUT_WAIT) || (next_state == ST_OUT_LINK);
            rate_detect_ready <= (next_state == ST_INBOUND);
            prompt_enable     <= next_prompt;
        end
    end

    assign rate_detect_enable    = cfg.rate_detect_enable;
    assign hotline_rate          = cfg.rate;
    assign interface_role_select = ROLE_DTE;
    assign hotline_select        = strap_mode || hot_mode;

    // apb slave, zero wait states, read data captured in setup
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign addr_hit     = (paddr == ADDR_CTRL) || (paddr == ADDR_GAP) || (paddr == ADDR_STATUS);
    assign pready       = 1'b1;
    assign pslverr      = access_phase && !addr_hit;

    assign status_word = 32'(state) << STAT_STATE_LSB
                       | 32'(dtr_out) << STAT_DTR_BIT
                       | 32'(busy_outbound) << STAT_BUSY_BIT
                       | 32'(prompt_enable) << STAT_PROMPT_BIT
                       | 32'(leads_q.dcd) << STAT_DCD_BIT
                       | 32'(leads_q.dsr) << STAT_DSR_BIT;

    assign read_word = (paddr == ADDR_CTRL) ? (32'(cfg.mode) << CTRL_MODE_LSB
                                             | 32'(cfg.rate_detect_enable) << CTRL_RATE_DET_BIT
                                             | 32'(cfg.rate) << CTRL_RATE_LSB) :
                       (paddr == ADDR_GAP)    ? 32'(hotline_gap) :
                       (paddr == ADDR_STATUS) ? status_word : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg         <= '{rate: CTRL_RATE_RESET, rate_detect_enable: CTRL_RATE_DET_RESET, mode: CTRL_MODE_RESET};
            hotline_gap <= TIMER_W'(HOTLINE_GAP_RST);
            prdata      <= 32'h0;
        end else begin
            if (setup_phase && !pwrite) begin
                prdata <= read_word;
            end
            if (access_phase && pwrite && (paddr == ADDR_CTRL)) begin
                cfg.mode               <= pwdata[CTRL_MODE_LSB +: MODE_W];
                cfg.rate_detect_enable <= pwdata[CTRL_RATE_DET_BIT];
                cfg.rate               <= pwdata[CTRL_RATE_LSB +: RATE_W];
            end
            if (access_phase && pwrite && (paddr == ADDR_GAP)) begin
                hotline_gap <= pwdata[TIMER_W-1:0];
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence inbound_taken;
        (state == ST_INBOUND) && dtr_out && busy_outbound && rate_detect_ready;
    endsequence

    sequence dtr_dropped;
        !dtr_out [*8];
    endsequence

    AST_DTR_IDLE_OFF: assert property (state == ST_IDLE && $stable(cfg) && gw_mode && !pulse_mode |-> !dtr_out)
        else $error("dtr high in idle in modes 4 or 5");

    AST_DTR_IDLE_ON: assert property ((state == ST_IDLE) && $stable(cfg) && pulse_mode |-> dtr_out)
        else $error("dtr low in idle in modes 6 or 7");

    AST_DTR_DROP: assert property ($rose(state == ST_DISC) && $stable(cfg) |-> dtr_dropped)
        else $error("disconnect drop of dtr too short");

    AST_RELEASE_ON_FALL: assert property (established && gw_mode && ($fell(dcd_in) || $fell(dsr_in))
                                          |=> call_release)
        else $error("lead fall did not release the call");

    AST_CARRIER_TIMEOUT: assert property ((state == ST_OUT_WAIT) && timer_expired && !dcd_in && !peer_release
                                          && gw_mode && !pulse_mode
                                          |=> call_release && !dtr_out && (state == ST_IDLE))
        else $error("carrier timeout did not drop dtr and release");

    AST_INBOUND_START: assert property (state == ST_IDLE && dcd_rise && gw_mode && !hot_mode |=> inbound_taken)
        else $error("carrier rise did not start inbound call");

    AST_HOTLINE_START: assert property ((state == ST_IDLE) && dcd_rise && hot_mode
                                        |=> hotline_place && (state == ST_HOT_CALL))
        else $error("carrier rise did not place hotline call");

    AST_PROMPT_OUTBOUND: assert property (transparent_link |-> !prompt_enable)
        else $error("prompts enabled on outbound link");

    AST_PROMPT_NO_DCD: assert property (!dcd_in |=> !prompt_enable)
        else $error("prompts enabled while carrier off");

    AST_OUTBOUND_ANSWER: assert property ((state == ST_IDLE) && call_offer && gw_mode && !hot_mode && !dcd_rise
                                          |=> call_answer && transparent_link && dtr_out)
        else $error("outbound call not answered with dtr");

    AST_REFUSE_BUSY: assert property (call_offer && (state != ST_IDLE) |=> call_refuse && !call_answer)
        else $error("offer accepted while busy");

    AST_STRAP_MODE: assert property (strap_mode && $stable(cfg) |-> dtr_out && hotline_select && !prompt_enable)
        else $error("strap mode settings wrong");

endmodule
`default_nettype wire

// *** dv/gcls_gateway.sv ***
// gateway model: drives carrier and ready leads, watches dtr
`timescale 1ns/1ps
`default_nettype none
module gcls_gateway (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       dtr,
    input  wire logic       pending,
    input  wire logic       carrier,
    input  wire logic       dsr_drop,
    input  wire logic [7:0] lag,
    output logic            dcd,
    output logic            dsr
);
    logic [7:0] age;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age <= 8'h00;
            dcd <= 1'b0;
            dsr <= 1'b0;
        end else begin
            age <= (carrier && dtr) ? ((age == 8'hff) ? age : age + 8'h01) : 8'h00;
            dcd <= pending || (carrier && dtr && age >= lag);
            dsr <= !dsr_drop;
        end
    end
endmodule
`default_nettype wire

// *** dv/gcls_top_test.sv ***
// self-checking bench for the gateway control lead sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module gcls_top_test;
    import gcls_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, dsr_in, dcd_in, dtr_out;
    logic        call_offer = 1'b0, peer_release = 1'b0, hotline_answered = 1'b0;
    logic        call_answer, call_refuse, call_release, hotline_place, busy_outbound;
    logic        transparent_link, rate_detect_ready, prompt_enable, rate_detect_enable;
    logic [3:0]  hotline_rate;
    logic        interface_role_select, hotline_select;
    logic        pending = 1'b0, carrier = 1'b0, dsr_drop = 1'b0;
    logic [7:0]  lag = 8'h00;
    int          fail_count = 0, checked = 0, cycles = 0, n_ans = 0, n_rel = 0, n_ref = 0, n_hot = 0;

    gcls_top #(.TICK_LEN(2), .CARRIER_TICKS(20), .HOTLINE_GAP_RST(5)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .dsr_in, .dcd_in, .dtr_out, .call_offer, .peer_release, .hotline_answered,
        .call_answer, .call_refuse, .call_release, .hotline_place, .busy_outbound,
        .transparent_link, .rate_detect_ready, .prompt_enable, .rate_detect_enable,
        .hotline_rate, .interface_role_select, .hotline_select);
    gcls_gateway gw (.pclk, .presetn, .dtr(dtr_out), .pending, .carrier, .dsr_drop, .lag,
        .dcd(dcd_in), .dsr(dsr_in));

    always #5 pclk = ~pclk;
    // pulse tallies, updated after each edge so readers never race
    always @(posedge pclk) begin
        cycles++;
        n_ans <= n_ans + int'(call_answer === 1'b1);
        n_rel <= n_rel + int'(call_release === 1'b1);
        n_ref <= n_ref + int'(call_refuse === 1'b1);
        n_hot <= n_hot + int'(hotline_place === 1'b1);
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic pulse_offer;
        call_offer <= 1'b1;
        @(posedge pclk) call_offer <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // length of the next dtr low stretch
    task automatic low_time(output int c);
        c = 0;
        for (int i = 0; i < 10 && dtr_out === 1'b1; i++) @(posedge pclk);
        while (dtr_out === 1'b0 && c < 500) begin
            @(posedge pclk);
            c++;
        end
    endtask

    task automatic t_reset;
        `CHK(dtr_out, 1'b0)
        `CHK(interface_role_select, ROLE_DTE)
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h0000_0014)
        apb(1'b0, ADDR_GAP, 32'h0);
        `CHK(rd, 32'h0000_0005)
        apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd, 32'h0000_0100)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK({er, rd}, 33'h1_0000_0000)
    endtask

    task automatic t_inbound;
        int r0;
        r0 = n_ref;
        pending <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK({dtr_out, busy_outbound, rate_detect_ready}, 3'h7)
        `CHK(prompt_enable, 1'b1)
        pulse_offer();
        `CHK(n_ref - r0, 1)
        r0 = n_rel;
        dsr_drop <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK(n_rel - r0, 1)
        `CHK(dtr_out, 1'b0)
        pending <= 1'b0;
        dsr_drop <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic t_out_timeout;
        int c, a0, r0;
        a0 = n_ans;
        r0 = n_rel;
        c = 0;
        pulse_offer();
        `CHK({transparent_link, dtr_out, prompt_enable}, 3'h6)
        while (dtr_out === 1'b1 && c < 100) begin
            @(posedge pclk);
            c++;
        end
        `CHK(c >= 34 && c <= 40, 1'b1)
        @(posedge pclk);
        `CHK({n_ans - a0, n_rel - r0}, {32'd1, 32'd1})
    endtask

    task automatic t_out6;
        int c, r0;
        apb(1'b1, ADDR_CTRL, 32'h0000_0016);
        @(posedge pclk);
        `CHK(dtr_out, 1'b1)
        lag <= 8'h1e;
        pulse_offer();
        carrier <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd[3:0], 4'h3)
        r0 = n_rel;
        peer_release <= 1'b1;
        carrier <= 1'b0;
        @(posedge pclk) peer_release <= 1'b0;
        low_time(c);
        `CHK(c >= 396 && c <= 404, 1'b1)
        `CHK({n_rel - r0, dtr_out}, {32'd1, 1'b1})
    endtask

    task automatic t_hot5;
        int h0;
        apb(1'b1, ADDR_GAP, 32'h0000_0003);
        apb(1'b1, ADDR_CTRL, 32'h0000_0a05);
        `CHK({hotline_rate, rate_detect_enable, hotline_select}, 6'h29)
        h0 = n_ref;
        pulse_offer();
        `CHK(n_ref - h0, 1)
        h0 = n_hot;
        pending <= 1'b1;
        repeat (32) @(posedge pclk);
        `CHK(n_hot - h0 >= 4, 1'b1)
        `CHK(prompt_enable, 1'b1)
        hotline_answered <= 1'b1;
        @(posedge pclk) hotline_answered <= 1'b0;
        repeat (3) @(posedge pclk);
        h0 = n_hot;
        repeat (20) @(posedge pclk);
        `CHK(n_hot - h0, 0)
        h0 = n_rel;
        pending <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK({n_rel - h0, dtr_out}, {32'd1, 1'b0})
    endtask

    task automatic t_modes;
        for (int i = 3; i < 8; i++) begin
            apb(1'b1, ADDR_CTRL, 32'h10 | i);
            @(posedge pclk);
            `CHK(hotline_select, i[0])
            `CHK(dtr_out, i != 4 && i != 5)
        end
    endtask

    task automatic t_hot7;
        int c;
        pending <= 1'b1;
        repeat (4) @(posedge pclk);
        hotline_answered <= 1'b1;
        @(posedge pclk) hotline_answered <= 1'b0;
        repeat (3) @(posedge pclk);
        pending <= 1'b0;
        low_time(c);
        `CHK(c >= 396 && c <= 404, 1'b1)
        `CHK(dtr_out, 1'b1)
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_inbound();
        t_out_timeout();
        t_out6();
        t_hot5();
        t_modes();
        t_hot7();
        report_and_stop();
    end
endmodule
`default_nettype wire
